// *** common/comparator_control_pkg.sv ***
// Constants, register map and carrier types for the two-comparator control block.
// Assumes a 32-bit AXI4-Lite register bus and an analog core that takes the decoded controls below.
package comparator_control_pkg;

    localparam int NUM_CMP = 2;
    localparam int EXT_INPUTS = 8;
    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] ZERO_CTRL_INDEX = 8'h9b;
    localparam logic [7:0] ZERO_MODE_INDEX = 8'h9d;
    localparam logic [7:0] ZERO_MUX_INDEX = 8'h9f;
    localparam logic [7:0] ONE_CTRL_INDEX = 8'ha3;
    localparam logic [7:0] ONE_MODE_INDEX = 8'ha5;
    localparam logic [7:0] ONE_MUX_INDEX = 8'ha7;
    localparam logic [NUM_CMP-1:0][7:0] CTRL_INDEX = {ONE_CTRL_INDEX, ZERO_CTRL_INDEX};
    localparam logic [NUM_CMP-1:0][7:0] MODE_INDEX = {ONE_MODE_INDEX, ZERO_MODE_INDEX};
    localparam logic [NUM_CMP-1:0][7:0] MUX_INDEX = {ONE_MUX_INDEX, ZERO_MUX_INDEX};

    // Control register fields.
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;

    // Mode register fields.
    localparam int MODE_LATCH_BIT = 7;
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_RESP_LSB = 0;

    // Input select register fields.
    localparam int MUX_POS_LSB = 0;
    localparam int MUX_NEG_LSB = 4;

    // Reset values and select codes.
    localparam logic [1:0] HYST_RESET = 2'h0;
    localparam logic [1:0] RESP_MODE_RESET = 2'h2;
    localparam logic [3:0] SEL_RESET = 4'hf;
    localparam logic [3:0] SEL_INTERNAL = 4'h8;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Controls handed to one analog comparator.
    typedef struct packed {
        logic power_on;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
        logic [1:0] resp_mode;
        logic [EXT_INPUTS-1:0] pos_ext;
        logic pos_regulator;
        logic [EXT_INPUTS-1:0] neg_ext;
        logic neg_ground;
    } analog_ctrl_t;

    // Comparator zero's level offered to other blocks.
    typedef struct packed {
        logic reset_request;
        logic counter_array_kill;
    } trigger_out_t;

endpackage : comparator_control_pkg

// *** hdl/comparator_control.sv ***
// Digital control for two analog comparators: input selects, enable, edge flags, routing and triggers.
// Assumes raw comparator outputs are asynchronous and the counter overflow pulse is on ref_clk.
`timescale 1ns/10ps

module comparator_control
    import comparator_control_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog core.
    input wire logic [NUM_CMP-1:0] raw_out,
    output analog_ctrl_t [NUM_CMP-1:0] analog_ctrl,
    // Crossbar, interrupt and trigger outputs.
    output logic [NUM_CMP-1:0] crossbar_sync,
    output logic [NUM_CMP-1:0] crossbar_async,
    output logic [NUM_CMP-1:0] cmp_irq,
    output trigger_out_t trigger_out,
    // Counter array overflow pulse.
    input wire logic counter_array_overflow
);

    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic next_aw_full;
    logic next_w_full;
    logic next_bvalid;
    logic next_rvalid;
    logic commit;
    logic [7:0] wr_index;
    logic wr_mapped;
    logic [7:0] rd_index;
    logic rd_mapped;
    logic [7:0] rd_byte;

    logic [NUM_CMP-1:0] enable;
    logic [NUM_CMP-1:0] rise_flag;
    logic [NUM_CMP-1:0] fall_flag;
    logic [NUM_CMP-1:0][1:0] pos_hyst;
    logic [NUM_CMP-1:0][1:0] neg_hyst;
    logic [NUM_CMP-1:0] latched;
    logic [NUM_CMP-1:0] rise_ie;
    logic [NUM_CMP-1:0] fall_ie;
    logic [NUM_CMP-1:0][1:0] resp_mode;
    logic [NUM_CMP-1:0][3:0] pos_sel;
    logic [NUM_CMP-1:0][3:0] neg_sel;
    logic [NUM_CMP-1:0] sync_1;
    logic [NUM_CMP-1:0] sync_2;
    logic [NUM_CMP-1:0] out_prev;

    // Codes above the last pin select nothing, which also covers the reserved range.
    function automatic logic [EXT_INPUTS-1:0] decode_ext(input logic [3:0] sel);
        logic [EXT_INPUTS-1:0] onehot;
        onehot = '0;
        if (sel < 4'(EXT_INPUTS)) begin
            onehot[sel[2:0]] = 1'b1;
        end
        return onehot;
    endfunction : decode_ext

    function automatic logic is_mapped(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        for (int c = 0; c < NUM_CMP; c++) begin
            if (idx == CTRL_INDEX[c] || idx == MODE_INDEX[c] || idx == MUX_INDEX[c]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : is_mapped

    // The upper address bits must be zero, so aliases above the map answer as unmapped.
    always_comb begin
        wr_index = aw_addr[9:2];
        wr_mapped = (aw_addr[ADDR_W-1:10] == '0) && (aw_addr[1:0] == 2'h0) && is_mapped(wr_index);
        rd_index = s_axi_araddr[9:2];
        rd_mapped = (s_axi_araddr[ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'h0) && is_mapped(rd_index);
        commit = aw_full && w_full && !s_axi_bvalid;
    end

    // Address and data are held independently; the write commits once both are present.
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_bvalid = s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
        end
        if (commit) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_rvalid = s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_bvalid <= next_bvalid;
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready <= !next_w_full && !next_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (commit) begin
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Reads only sample state; nothing is cleared or altered by them.
    always_comb begin
        rd_byte = 8'h00;
        for (int c = 0; c < NUM_CMP; c++) begin
            if (rd_index == CTRL_INDEX[c]) begin
                rd_byte[CTRL_ENABLE_BIT] = enable[c];
                rd_byte[CTRL_OUT_BIT] = crossbar_sync[c];
                rd_byte[CTRL_RISE_BIT] = rise_flag[c];
                rd_byte[CTRL_FALL_BIT] = fall_flag[c];
                rd_byte[CTRL_HYP_LSB +: 2] = pos_hyst[c];
                rd_byte[CTRL_HYN_LSB +: 2] = neg_hyst[c];
            end
            if (rd_index == MODE_INDEX[c]) begin
                rd_byte[MODE_LATCH_BIT] = latched[c];
                rd_byte[MODE_RIE_BIT] = rise_ie[c];
                rd_byte[MODE_FIE_BIT] = fall_ie[c];
                rd_byte[MODE_RESP_LSB +: 2] = resp_mode[c];
            end
            if (rd_index == MUX_INDEX[c]) begin
                rd_byte[MUX_POS_LSB +: 4] = pos_sel[c];
                rd_byte[MUX_NEG_LSB +: 4] = neg_sel[c];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Comparator zero's clocked level serves the reset controller and the counter kill input.
    assign trigger_out.reset_request = crossbar_sync[0];
    assign trigger_out.counter_array_kill = crossbar_sync[0];

    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        logic wr_ctrl;
        logic wr_mode;
        logic wr_mux;
        logic rise_edge;
        logic fall_edge;

        assign wr_ctrl = commit && wr_mapped && w_lane0 && (wr_index == CTRL_INDEX[i]);
        assign wr_mode = commit && wr_mapped && w_lane0 && (wr_index == MODE_INDEX[i]);
        assign wr_mux = commit && wr_mapped && w_lane0 && (wr_index == MUX_INDEX[i]);

        // The unclocked path cannot come from a flip-flop; it is only gated by the enable.
        assign crossbar_async[i] = raw_out[i] & enable[i];

        // Only the second stage is looked at by any logic.
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                sync_1[i] <= 1'b0;
                sync_2[i] <= 1'b0;
            end else begin
                sync_1[i] <= raw_out[i];
                sync_2[i] <= sync_1[i];
            end
        end

        // Disabling forces the level low, so it can flag a falling edge that firmware must clear.
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                crossbar_sync[i] <= 1'b0;
                out_prev[i] <= 1'b0;
            end else begin
                crossbar_sync[i] <= sync_2[i] & enable[i];
                out_prev[i] <= crossbar_sync[i];
            end
        end

        assign rise_edge = crossbar_sync[i] & ~out_prev[i];
        assign fall_edge = ~crossbar_sync[i] & out_prev[i];

        // A hardware edge beats a clearing write in the same cycle.
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                rise_flag[i] <= 1'b0;
                fall_flag[i] <= 1'b0;
            end else begin
                rise_flag[i] <= rise_edge | (wr_ctrl ? w_byte[CTRL_RISE_BIT] : rise_flag[i]);
                fall_flag[i] <= fall_edge | (wr_ctrl ? w_byte[CTRL_FALL_BIT] : fall_flag[i]);
            end
        end

        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                enable[i] <= 1'b0;
                pos_hyst[i] <= HYST_RESET;
                neg_hyst[i] <= HYST_RESET;
            end else if (wr_ctrl) begin
                enable[i] <= w_byte[CTRL_ENABLE_BIT];
                pos_hyst[i] <= w_byte[CTRL_HYP_LSB +: 2];
                neg_hyst[i] <= w_byte[CTRL_HYN_LSB +: 2];
            end
        end

        // An overflow in the same cycle as a write wins, so the sample is never lost.
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                latched[i] <= 1'b0;
                rise_ie[i] <= 1'b0;
                fall_ie[i] <= 1'b0;
                resp_mode[i] <= RESP_MODE_RESET;
            end else begin
                if (counter_array_overflow) begin
                    latched[i] <= crossbar_sync[i];
                end else if (wr_mode) begin
                    latched[i] <= w_byte[MODE_LATCH_BIT];
                end
                if (wr_mode) begin
                    rise_ie[i] <= w_byte[MODE_RIE_BIT];
                    fall_ie[i] <= w_byte[MODE_FIE_BIT];
                    resp_mode[i] <= w_byte[MODE_RESP_LSB +: 2];
                end
            end
        end

        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                pos_sel[i] <= SEL_RESET;
                neg_sel[i] <= SEL_RESET;
            end else if (wr_mux) begin
                pos_sel[i] <= w_byte[MUX_POS_LSB +: 4];
                neg_sel[i] <= w_byte[MUX_NEG_LSB +: 4];
            end
        end

        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                cmp_irq[i] <= 1'b0;
            end else begin
                cmp_irq[i] <= (rise_flag[i] & rise_ie[i]) | (fall_flag[i] & fall_ie[i]);
            end
        end

        // Decoded switch controls go to the analog core one cycle after the register changes.
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                analog_ctrl[i] <= '0;
            end else begin
                analog_ctrl[i].power_on <= enable[i];
                analog_ctrl[i].pos_hyst <= pos_hyst[i];
                analog_ctrl[i].neg_hyst <= neg_hyst[i];
                analog_ctrl[i].resp_mode <= resp_mode[i];
                analog_ctrl[i].pos_ext <= decode_ext(pos_sel[i]);
                analog_ctrl[i].pos_regulator <= (pos_sel[i] == SEL_INTERNAL);
                analog_ctrl[i].neg_ext <= decode_ext(neg_sel[i]);
                analog_ctrl[i].neg_ground <= (neg_sel[i] == SEL_INTERNAL);
            end
        end
    end

endmodule : comparator_control

// *** verification/comparator_control_chk.sv ***
// Checker for comparator_control: bus answers, output gating, tracking and triggers.
// Assumes it is bound to comparator_control and sees only that module's ports.
`timescale 1ns/10ps
module comparator_control_chk
    import comparator_control_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Comparator side.
    input wire logic [NUM_CMP-1:0] raw_out,
    input wire analog_ctrl_t [NUM_CMP-1:0] analog_ctrl,
    input wire logic [NUM_CMP-1:0] crossbar_sync,
    input wire logic [NUM_CMP-1:0] crossbar_async,
    input wire trigger_out_t trigger_out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_commit_then_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    chk_write_answer: assert property (s_write_taken |=> s_commit_then_answer)
        else $error("write response not one cycle after commit");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not returned after address");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    chk_trigger_pair: assert property (trigger_out == {2{crossbar_sync[0]}})
        else $error("reset request or kill trigger differs from comparator zero");

    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        chk_async_off: assert property (!analog_ctrl[i].power_on |-> !$past(crossbar_async[i]))
            else $error("unclocked output high while disabled");
        chk_sync_off: assert property (!analog_ctrl[i].power_on |-> !crossbar_sync[i])
            else $error("clocked output high while disabled");
        chk_async_track: assert property (analog_ctrl[i].power_on |-> $past(crossbar_async[i]) == $past(raw_out[i]))
            else $error("unclocked output does not follow comparator");
        chk_sync_track: assert property (analog_ctrl[i].power_on
            && $past(raw_out[i], 2) == $past(raw_out[i], 3) && $past(raw_out[i], 3) == $past(raw_out[i], 4)
            |-> crossbar_sync[i] == $past(raw_out[i], 2))
            else $error("clocked output does not follow comparator");
        chk_select_onehot: assert property (
            $onehot0({analog_ctrl[i].pos_ext, analog_ctrl[i].pos_regulator})
            && $onehot0({analog_ctrl[i].neg_ext, analog_ctrl[i].neg_ground}))
            else $error("more than one input selected");
        chk_ctrl_from_write: assert property ($changed({analog_ctrl[i].power_on,
            analog_ctrl[i].pos_hyst, analog_ctrl[i].neg_hyst, analog_ctrl[i].pos_ext, analog_ctrl[i].neg_ext})
            |-> $past(s_axi_bvalid))
            else $error("analog controls changed without a write");
    end
endmodule : comparator_control_chk

bind comparator_control comparator_control_chk i_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .raw_out(raw_out),
    .analog_ctrl(analog_ctrl), .crossbar_sync(crossbar_sync), .crossbar_async(crossbar_async),
    .trigger_out(trigger_out)
);

// *** verification/analog_core_model.sv ***
// Behavioural model of the two analog comparators behind the control block.
// Assumes level_cmd is the input relation chosen by the bench; resp_mode sets the delay.
`timescale 1ns/10ps
module analog_core_model
    import comparator_control_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Controls from the block and levels from the bench.
    input wire analog_ctrl_t [NUM_CMP-1:0] analog_ctrl,
    input wire logic [NUM_CMP-1:0] level_cmd,
    // Raw comparator outputs.
    output logic [NUM_CMP-1:0] raw_out
);
    logic [NUM_CMP-1:0][3:0] history = '0;
    initial raw_out = '0;
    // An unpowered comparator has no defined level, so its output keeps flipping.
    always @(posedge ref_clk) begin
        for (int i = 0; i < NUM_CMP; i++) begin
            history[i] <= {history[i][2:0], level_cmd[i]};
            raw_out[i] <= analog_ctrl[i].power_on ? history[i][analog_ctrl[i].resp_mode] : ~raw_out[i];
        end
    end
endmodule : analog_core_model

// *** verification/comparator_control_test.sv ***
// Testbench for comparator_control: registers, input decode, edge flags, gating and latch.
// Assumes the analog core model drives raw_out and the checker is bound on its own.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module comparator_control_test
    import comparator_control_pkg::*;
;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, counter_array_overflow = 1'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [NUM_CMP-1:0] raw_out, crossbar_sync, crossbar_async, cmp_irq;
    logic [NUM_CMP-1:0] level_cmd = '0;
    analog_ctrl_t [NUM_CMP-1:0] analog_ctrl;
    trigger_out_t trigger_out;
    int err_total = 0;
    int n_compared = 0;

    comparator_control i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .raw_out(raw_out), .analog_ctrl(analog_ctrl),
        .crossbar_sync(crossbar_sync), .crossbar_async(crossbar_async), .cmp_irq(cmp_irq),
        .trigger_out(trigger_out), .counter_array_overflow(counter_array_overflow)
    );
    analog_core_model i_core (.ref_clk(ref_clk), .analog_ctrl(analog_ctrl), .level_cmd(level_cmd), .raw_out(raw_out));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : ticks

    // Address and data are offered together and each is released at its own handshake.
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
        int n = 0;
        logic done = 1'h0;
        @(posedge ref_clk);
        s_axi_awaddr <= ADDR_W'({idx, 2'h0});
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!done && n < 50) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                done = 1'h1;
                resp = s_axi_bresp;
                s_axi_bready <= 1'h0;
            end
        end
        if (!done) begin
            err_total++;
            end_of_test();
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        int n = 0;
        logic done = 1'h0;
        @(posedge ref_clk);
        s_axi_araddr <= ADDR_W'({idx, 2'h0});
        s_axi_arvalid <= 1'h1;
        while (!done && n < 50) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            // Ready follows valid by one cycle, so the slave has to hold its answer.
            if (s_axi_rvalid && s_axi_rready) begin
                done = 1'h1;
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'h0;
            end else if (s_axi_rvalid) begin
                s_axi_rready <= 1'h1;
            end
        end
        if (!done) begin
            err_total++;
            end_of_test();
        end
    endtask : axi_read

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_write(idx, d, r);
        `CHK("write response", RESP_OKAY, r)
    endtask : wr

    task automatic check_reg(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        `CHK("register read", {RESP_OKAY, exp}, {r, d})
    endtask : check_reg

    task automatic overflow_pulse();
        counter_array_overflow <= 1'h1;
        ticks(1);
        counter_array_overflow <= 1'h0;
        ticks(2);
    endtask : overflow_pulse

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [8:0] e_pos, e_neg;
        analog_ctrl_t a;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'h1;
        for (int i = 0; i < NUM_CMP; i++) begin
            check_reg(CTRL_INDEX[i], 32'h0);
            check_reg(MODE_INDEX[i], {30'h0, RESP_MODE_RESET});
            check_reg(MUX_INDEX[i], 32'hff);
        end
        axi_read(8'h9c, d, r);
        `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
        axi_write(8'h9c, 8'h80, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        s_axi_wstrb <= 4'h0;
        wr(CTRL_INDEX[0], 8'h80);
        s_axi_wstrb <= 4'hf;
        check_reg(CTRL_INDEX[0], 32'h0);
        for (int i = 0; i < NUM_CMP; i++) begin
            for (int c = 0; c < 16; c++) begin
                wr(MUX_INDEX[i], 8'((15 - c) << 4 | c));
                ticks(2);
                a = analog_ctrl[i];
                e_pos = (c < 8) ? 9'h2 << c : 9'(c == 8);
                e_neg = (c > 7) ? 9'h2 << (15 - c) : 9'(c == 7);
                `CHK("positive select", e_pos, {a.pos_ext, a.pos_regulator})
                `CHK("negative select", e_neg, {a.neg_ext, a.neg_ground})
            end
            for (int h = 0; h < 4; h++) begin
                wr(CTRL_INDEX[i], 8'(8'h80 | h << 2 | (3 - h)));
                ticks(2);
                a = analog_ctrl[i];
                `CHK("hysteresis", {1'h1, 2'(h), 2'(3 - h)}, {a.power_on, a.pos_hyst, a.neg_hyst})
                `CHK("response mode", RESP_MODE_RESET, a.resp_mode)
            end
            // Power-up may flag false edges, so settle and clear before unmasking.
            ticks(8);
            wr(CTRL_INDEX[i], 8'h80);
            wr(MODE_INDEX[i], 8'h32);
            ticks(2);
            `CHK("quiet interrupt", 1'h0, cmp_irq[i])
            level_cmd[i] <= 1'h1;
            ticks(10);
            `CHK("outputs high", 3'h7, {crossbar_sync[i], crossbar_async[i], cmp_irq[i]})
            if (i == 0) `CHK("triggers", 2'h3, trigger_out)
            check_reg(CTRL_INDEX[i], 32'he0);
            check_reg(CTRL_INDEX[i], 32'he0);
            wr(MODE_INDEX[i], 8'h12);
            ticks(2);
            `CHK("masked rising", 1'h0, cmp_irq[i])
            level_cmd[i] <= 1'h0;
            ticks(10);
            check_reg(CTRL_INDEX[i], 32'hb0);
            `CHK("falling interrupt", 1'h1, cmp_irq[i])
            wr(MODE_INDEX[i], 8'h02);
            ticks(2);
            `CHK("masked falling", 1'h0, cmp_irq[i])
            wr(CTRL_INDEX[i], 8'h80);
            check_reg(CTRL_INDEX[i], 32'h80);
            level_cmd[i] <= 1'h1;
            ticks(10);
            overflow_pulse();
            level_cmd[i] <= 1'h0;
            ticks(10);
            check_reg(MODE_INDEX[i], 32'h82);
            overflow_pulse();
            check_reg(MODE_INDEX[i], 32'h02);
            level_cmd[i] <= 1'h1;
            ticks(10);
            wr(CTRL_INDEX[i], 8'h40);
            ticks(4);
            `CHK("disabled outputs", 3'h0, {crossbar_sync[i], crossbar_async[i], analog_ctrl[i].power_on})
            axi_read(CTRL_INDEX[i], d, r);
            `CHK("read-only output bit", 2'h0, d[7:6])
            level_cmd[i] <= 1'h0;
        end
        end_of_test();
    end
endmodule : comparator_control_test
